// ### include/tcwi_pkg.sv
package tcwi_pkg;

  // ***********************************************************
  // Operating modes
  // ***********************************************************
  typedef enum logic [2:0] {
    TCWI_MODE_INTERVAL   = 3'h0,
    TCWI_MODE_EXT_EVENT  = 3'h1,
    TCWI_MODE_EXT_TRIG   = 3'h2,
    TCWI_MODE_ONE_SHOT   = 3'h3,
    TCWI_MODE_PWM        = 3'h4,
    TCWI_MODE_FREE_RUN   = 3'h5,
    TCWI_MODE_PULSE_MEAS = 3'h6,
    TCWI_MODE_RESERVED   = 3'h7
  } tcwi_mode_t;

  // ***********************************************************
  // Edge select encodings
  // ***********************************************************
  localparam logic [1:0] TCWI_EDGE_NONE = 2'h0;
  localparam logic [1:0] TCWI_EDGE_RISE = 2'h1;
  localparam logic [1:0] TCWI_EDGE_FALL = 2'h2;
  localparam logic [1:0] TCWI_EDGE_BOTH = 2'h3;

  // ***********************************************************
  // Reset values
  // ***********************************************************
  localparam logic [2:0] TCWI_MODE_RST    = 3'h0;
  localparam logic [1:0] TCWI_OUT_LVL_RST = 2'h0;
  localparam logic [1:0] TCWI_OUT_EN_RST  = 2'h0;
  localparam logic [3:0] TCWI_CAP_SEL_RST = 4'h0;
  localparam logic [1:0] TCWI_EES_RST     = 2'h0;
  localparam logic [1:0] TCWI_ETS_RST     = 2'h0;

  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int TCWI_CAP0_LSB = 0;
  localparam int TCWI_CAP1_LSB = 2;

endpackage : tcwi_pkg

// ### logic/tcwi_edge_det.sv
module tcwi_edge_det (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  // Pin and selection
  input  wire logic       pin_i,
  input  wire logic [1:0] sel_i,
  input  wire logic       en_i,
  // Detected edge
  output logic            hit_o
);

  // ***********************************************************
  // Synchroniser and edge detection
  // ***********************************************************
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic       hit_q;
  logic       hit_d;

  always_comb begin
    sync_d = {sync_q[1:0], pin_i};
    hit_d  = 1'b0;
    if (en_i) begin
      case (sel_i)
        tcwi_pkg::TCWI_EDGE_RISE: hit_d = sync_q[1] & ~sync_q[2];
        tcwi_pkg::TCWI_EDGE_FALL: hit_d = ~sync_q[1] & sync_q[2];
        tcwi_pkg::TCWI_EDGE_BOTH: hit_d = sync_q[1] ^ sync_q[2];
        default:                  hit_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      sync_q <= 3'h0;
      hit_q  <= 1'b0;
    end else begin
      sync_q <= sync_d;
      hit_q  <= hit_d;
    end
  end

  assign hit_o = hit_q;

endmodule : tcwi_edge_det

// ### logic/tcwi_top.sv
// Summary of operation
// - Event count mode always uses event input
// - Running change of select or mode undefined
// - Same value write while running is harmless
// - Output pin follows level bit when stopped or disabled
// - Capture only in free-run or pulse-measure
// - Mode value 001 is event count
// - Event edge used when selected or event mode
// - Trigger edge used only modes 010, 011
module tcwi_top (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  // Control settings
  input  wire logic       count_run_i,
  input  wire logic       ext_event_input_sel_i,
  input  wire logic [2:0] operating_mode_field_i,
  input  wire logic [1:0] out_level_chan_i,
  input  wire logic [1:0] out_enable_chan_i,
  input  wire logic [3:0] capture_edge_sel_i,
  input  wire logic [1:0] event_edge_sel_i,
  input  wire logic [1:0] trigger_edge_sel_i,
  // Configuration write strobes
  input  wire logic       ctrl_wr_i,
  input  wire logic       out_wr_i,
  input  wire logic       cap_wr_i,
  input  wire logic       evtrg_wr_i,
  // Counter engine timer output levels
  input  wire logic [1:0] engine_out_i,
  // Pins
  input  wire logic       ext_event_pin_i,
  input  wire logic       ext_trigger_pin_i,
  input  wire logic [1:0] capture_pin_i,
  output logic [1:0]      timer_output_pin_o,
  // Status and events to counter engine
  output logic            count_from_event_o,
  output logic            event_edge_o,
  output logic            trigger_edge_o,
  output logic [1:0]      capture_o,
  output logic [2:0]      mode_o,
  output logic            locked_write_o
);

  // ***********************************************************
  // Configuration registers
  // ***********************************************************
  logic       ees_q,   ees_d;
  logic [2:0] mode_q,  mode_d;
  logic [1:0] lvl_q,   lvl_d;
  logic [1:0] oen_q,   oen_d;
  logic [3:0] cap_q,   cap_d;
  logic [1:0] evs_q,   evs_d;
  logic [1:0] trs_q,   trs_d;
  logic       lockw_q, lockw_d;

  function automatic logic changed_w(input logic wr, input logic [3:0] a, input logic [3:0] b);
    changed_w = wr & (a != b);
  endfunction : changed_w

  // A differing write while running still lands; behaviour is then undefined.
  always_comb begin
    ees_d   = ees_q;
    mode_d  = mode_q;
    lvl_d   = lvl_q;
    oen_d   = oen_q;
    cap_d   = cap_q;
    evs_d   = evs_q;
    trs_d   = trs_q;
    if (ctrl_wr_i) begin
      ees_d  = ext_event_input_sel_i;
      mode_d = operating_mode_field_i;
    end
    if (out_wr_i) begin
      lvl_d = out_level_chan_i;
      oen_d = out_enable_chan_i;
    end
    if (cap_wr_i) begin
      cap_d = capture_edge_sel_i;
    end
    if (evtrg_wr_i) begin
      evs_d = event_edge_sel_i;
      trs_d = trigger_edge_sel_i;
    end
    // Flags a locked field that really changes while running.
    lockw_d = count_run_i & (
      changed_w(ctrl_wr_i, {ext_event_input_sel_i, operating_mode_field_i},
                {ees_q, mode_q}) |
      changed_w(out_wr_i, {out_level_chan_i, out_enable_chan_i}, {lvl_q, oen_q}) |
      changed_w(cap_wr_i, capture_edge_sel_i, cap_q) |
      changed_w(evtrg_wr_i, {event_edge_sel_i, trigger_edge_sel_i}, {evs_q, trs_q}));
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ees_q   <= 1'b0;
      mode_q  <= tcwi_pkg::TCWI_MODE_RST;
      lvl_q   <= tcwi_pkg::TCWI_OUT_LVL_RST;
      oen_q   <= tcwi_pkg::TCWI_OUT_EN_RST;
      cap_q   <= tcwi_pkg::TCWI_CAP_SEL_RST;
      evs_q   <= tcwi_pkg::TCWI_EES_RST;
      trs_q   <= tcwi_pkg::TCWI_ETS_RST;
      lockw_q <= 1'b0;
    end else begin
      ees_q   <= ees_d;
      mode_q  <= mode_d;
      lvl_q   <= lvl_d;
      oen_q   <= oen_d;
      cap_q   <= cap_d;
      evs_q   <= evs_d;
      trs_q   <= trs_d;
      lockw_q <= lockw_d;
    end
  end

  // ***********************************************************
  // Mode decoding
  // ***********************************************************
  logic mode_evt;
  logic mode_trg;
  logic mode_cap;
  logic evt_en;

  always_comb begin
    mode_evt = (mode_q == tcwi_pkg::TCWI_MODE_EXT_EVENT);
    mode_trg = (mode_q == tcwi_pkg::TCWI_MODE_EXT_TRIG) ||
               (mode_q == tcwi_pkg::TCWI_MODE_ONE_SHOT);
    mode_cap = (mode_q == tcwi_pkg::TCWI_MODE_FREE_RUN) ||
               (mode_q == tcwi_pkg::TCWI_MODE_PULSE_MEAS);
    evt_en   = ees_q | mode_evt;
  end

  // ***********************************************************
  // Edge detectors
  // ***********************************************************
  logic       evt_hit;
  logic       trg_hit;
  logic [1:0] cap_hit;

  tcwi_edge_det u_evt (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .pin_i     (ext_event_pin_i),
    .sel_i     (evs_q),
    .en_i      (evt_en),
    .hit_o     (evt_hit)
  );

  tcwi_edge_det u_trg (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .pin_i     (ext_trigger_pin_i),
    .sel_i     (trs_q),
    .en_i      (mode_trg & count_run_i),
    .hit_o     (trg_hit)
  );

  tcwi_edge_det u_cap0 (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .pin_i     (capture_pin_i[0]),
    .sel_i     (cap_q[tcwi_pkg::TCWI_CAP0_LSB +: 2]),
    .en_i      (mode_cap & count_run_i),
    .hit_o     (cap_hit[0])
  );

  tcwi_edge_det u_cap1 (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .pin_i     (capture_pin_i[1]),
    .sel_i     (cap_q[tcwi_pkg::TCWI_CAP1_LSB +: 2]),
    .en_i      (mode_cap & count_run_i),
    .hit_o     (cap_hit[1])
  );

  // ***********************************************************
  // Output stage
  // ***********************************************************
  logic [1:0] pin_q,  pin_d;
  logic       cfe_q,  cfe_d;
  logic       evo_q,  evo_d;
  logic       tro_q,  tro_d;
  logic [1:0] capo_q, capo_d;
  logic [2:0] modeo_q, modeo_d;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // Stopped or disabled channels show the level bit directly.
      pin_d[i] = (oen_q[i] && count_run_i) ? (engine_out_i[i] ^ lvl_q[i])
                                           : lvl_q[i];
    end
    cfe_d   = mode_evt | ees_q;
    evo_d   = evt_hit & evt_en;
    tro_d   = trg_hit & mode_trg;
    capo_d  = cap_hit & {2{mode_cap}};
    modeo_d = mode_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pin_q   <= 2'h0;
      cfe_q   <= 1'b0;
      evo_q   <= 1'b0;
      tro_q   <= 1'b0;
      capo_q  <= 2'h0;
      modeo_q <= tcwi_pkg::TCWI_MODE_RST;
    end else begin
      pin_q   <= pin_d;
      cfe_q   <= cfe_d;
      evo_q   <= evo_d;
      tro_q   <= tro_d;
      capo_q  <= capo_d;
      modeo_q <= modeo_d;
    end
  end

  assign timer_output_pin_o = pin_q;
  assign count_from_event_o = cfe_q;
  assign event_edge_o       = evo_q;
  assign trigger_edge_o     = tro_q;
  assign capture_o          = capo_q;
  assign mode_o             = modeo_q;
  assign locked_write_o     = lockw_q;

  // ***********************************************************
  // Assertions
  // ***********************************************************
  sequence s_stopped_lvl;
    !count_run_i && !oen_q[0];
  endsequence

  property p_evt_mode_src;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (mode_q == 3'h1) |=> count_from_event_o;
  endproperty
  a_evt_mode_src: assert property (p_evt_mode_src)
    else $error("event mode not counting from event input");

  property p_same_write;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (count_run_i && ctrl_wr_i && operating_mode_field_i == mode_q &&
       ext_event_input_sel_i == ees_q && !out_wr_i && !cap_wr_i && !evtrg_wr_i)
      |=> !locked_write_o;
  endproperty
  a_same_write: assert property (p_same_write)
    else $error("unchanged write flagged as locked write");

  property p_diff_write;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (count_run_i && ctrl_wr_i && operating_mode_field_i != mode_q) |=> locked_write_o;
  endproperty
  a_diff_write: assert property (p_diff_write)
    else $error("changed running write not flagged");

  property p_pin_follow;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      s_stopped_lvl |=> (timer_output_pin_o[0] == $past(lvl_q[0]));
  endproperty
  a_pin_follow: assert property (p_pin_follow)
    else $error("stopped output pin not following level bit");

  property p_no_capture;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      !mode_cap |=> (capture_o == 2'h0);
  endproperty
  a_no_capture: assert property (p_no_capture)
    else $error("capture outside capture modes");

  property p_evt_gate;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (!ees_q && mode_q != 3'h1) |=> !event_edge_o;
  endproperty
  a_evt_gate: assert property (p_evt_gate)
    else $error("event edge passed while not selected");

  property p_trg_gate;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (mode_q != 3'h2 && mode_q != 3'h3) |=> !trigger_edge_o;
  endproperty
  a_trg_gate: assert property (p_trg_gate)
    else $error("trigger edge passed outside trigger modes");

  property p_mode_load;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (ctrl_wr_i && !count_run_i) |=> ##1 (mode_o == $past(operating_mode_field_i, 2));
  endproperty
  a_mode_load: assert property (p_mode_load)
    else $error("mode write while stopped not applied");

endmodule : tcwi_top

// ### tb/tcwi_sw_model.sv
module tcwi_sw_model (
  // Clock
  input  wire logic       sys_clk_i,
  // Control settings
  output logic            count_run_o,
  output logic            ext_sel_o,
  output logic [2:0]      mode_o,
  output logic [1:0]      lvl_o,
  output logic [1:0]      oen_o,
  output logic [3:0]      cap_sel_o,
  output logic [1:0]      ees_o,
  output logic [1:0]      ets_o,
  // Write strobes
  output logic            ctrl_wr_o,
  output logic            out_wr_o,
  output logic            cap_wr_o,
  output logic            evtrg_wr_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ***********************************************************
  // Software writes
  // ***********************************************************
  // Fields carry the inverse between writes, so a field stored without its strobe shows up.
  initial begin
    {count_run_o, ext_sel_o, mode_o, lvl_o, oen_o, cap_sel_o, ees_o, ets_o} = '0;
    {ctrl_wr_o, out_wr_o, cap_wr_o, evtrg_wr_o} = '0;
  end

  task automatic run(input logic r);
    @(negedge sys_clk_i);
    count_run_o = r;
  endtask : run

  task automatic wr_ctrl(input logic s, input logic [2:0] m);
    @(negedge sys_clk_i);
    {ext_sel_o, mode_o, ctrl_wr_o} = {s, m, 1'b1};
    @(negedge sys_clk_i);
    {ext_sel_o, mode_o, ctrl_wr_o} = {~s, ~m, 1'b0};
  endtask : wr_ctrl

  task automatic wr_out(input logic [1:0] l, input logic [1:0] e);
    @(negedge sys_clk_i);
    {lvl_o, oen_o, out_wr_o} = {l, e, 1'b1};
    @(negedge sys_clk_i);
    {lvl_o, oen_o, out_wr_o} = {~l, ~e, 1'b0};
  endtask : wr_out

  task automatic wr_cap(input logic [3:0] c);
    @(negedge sys_clk_i);
    {cap_sel_o, cap_wr_o} = {c, 1'b1};
    @(negedge sys_clk_i);
    {cap_sel_o, cap_wr_o} = {~c, 1'b0};
  endtask : wr_cap

  task automatic wr_evt(input logic [1:0] e, input logic [1:0] t);
    @(negedge sys_clk_i);
    {ees_o, ets_o, evtrg_wr_o} = {e, t, 1'b1};
    @(negedge sys_clk_i);
    {ees_o, ets_o, evtrg_wr_o} = {~e, ~t, 1'b0};
  endtask : wr_evt
endmodule : tcwi_sw_model

// ### tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic       sys_clk;
  logic       nrst;
  logic       run, esel, cwr, owr, kwr, ewr, cfe, eve, tre, lwr;
  logic [2:0] mfld, mode;
  logic [1:0] lvl, oen, ees, ets, tpin, cap;
  logic [3:0] csel;
  logic       evp;
  logic       trp;
  logic [1:0] cpp;
  logic [1:0] eng;
  int         errors = 0;
  int         cmp_count = 0;
  int         n_ev = 0;
  int         n_tr = 0;
  int         n_cap = 0;
  int         n_lw = 0;

  always #12.5 sys_clk = ~sys_clk;

  tcwi_sw_model sw (.sys_clk_i(sys_clk), .count_run_o(run), .ext_sel_o(esel), .mode_o(mfld),
    .lvl_o(lvl), .oen_o(oen), .cap_sel_o(csel), .ees_o(ees), .ets_o(ets), .ctrl_wr_o(cwr),
    .out_wr_o(owr), .cap_wr_o(kwr), .evtrg_wr_o(ewr));

  tcwi_top dut (.sys_clk_i(sys_clk), .nrst_i(nrst), .count_run_i(run),
    .ext_event_input_sel_i(esel), .operating_mode_field_i(mfld), .out_level_chan_i(lvl),
    .out_enable_chan_i(oen), .capture_edge_sel_i(csel), .event_edge_sel_i(ees),
    .trigger_edge_sel_i(ets), .ctrl_wr_i(cwr), .out_wr_i(owr), .cap_wr_i(kwr),
    .evtrg_wr_i(ewr), .engine_out_i(eng), .ext_event_pin_i(evp), .ext_trigger_pin_i(trp),
    .capture_pin_i(cpp), .timer_output_pin_o(tpin), .count_from_event_o(cfe),
    .event_edge_o(eve), .trigger_edge_o(tre), .capture_o(cap), .mode_o(mode),
    .locked_write_o(lwr));

  // ***********************************************************
  // Pulse counters
  // ***********************************************************
  always @(posedge sys_clk) begin
    n_ev  <= n_ev + int'(eve);
    n_tr  <= n_tr + int'(tre);
    n_cap <= n_cap + int'(cap[0]) + int'(cap[1]);
    n_lw  <= n_lw + int'(lwr);
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Number of pin edges that one high pulse yields under an edge code.
  function automatic int n_edges(input logic [1:0] code);
    n_edges = (code == tcwi_pkg::TCWI_EDGE_BOTH) ? 2 : int'(code != tcwi_pkg::TCWI_EDGE_NONE);
  endfunction : n_edges

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  task automatic results;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task automatic t_pin;
    sw.wr_out(2'h2, 2'h0);
    cyc(1);
    chk(8'(tpin), 8'h02);
    sw.run(1'b1);
    eng = 2'h3;
    cyc(2);
    chk(8'(tpin), 8'h02);
    sw.run(1'b0);
    sw.wr_out(2'h2, 2'h3);
    sw.run(1'b1);
    cyc(2);
    chk(8'(tpin), 8'h01);
    eng = 2'h0;
    cyc(2);
    chk(8'(tpin), 8'h02);
    sw.run(1'b0);
  endtask : t_pin

  task automatic t_lock;
    int l0;
    sw.wr_ctrl(1'b0, 3'h0);
    sw.run(1'b1);
    l0 = n_lw;
    sw.wr_ctrl(1'b0, 3'h0);
    cyc(3);
    chk(8'(n_lw - l0), 8'h00);
    chk(8'(mode), 8'h00);
    sw.wr_ctrl(1'b0, 3'h5);
    sw.wr_out(2'h2, 2'h3);
    sw.wr_cap(4'h0);
    cyc(3);
    chk(8'(n_lw - l0), 8'h01);
    sw.wr_evt(2'h1, 2'h1);
    cyc(3);
    chk(8'(n_lw - l0), 8'h02);
    sw.run(1'b0);
    sw.wr_ctrl(1'b0, 3'h6);
    cyc(3);
    chk(8'(n_lw - l0), 8'h02);
    chk(8'(mode), 8'h06);
  endtask : t_lock

  task automatic t_edges(input logic s, input logic [2:0] m, input logic [1:0] es,
                         input logic [1:0] ts, input logic [3:0] cs);
    int e0;
    int t0;
    int c0;
    sw.wr_evt(es, ts);
    sw.wr_cap(cs);
    sw.wr_ctrl(s, m);
    cyc(1);
    chk(8'(cfe), 8'(s | (m == 3'h1)));
    chk(8'(mode), 8'(m));
    sw.run(1'b1);
    {e0, t0, c0} = {n_ev, n_tr, n_cap};
    {evp, trp, cpp} = 4'hF;
    cyc(8);
    {evp, trp, cpp} = 4'h0;
    cyc(6);
    sw.run(1'b0);
    chk(8'(n_ev - e0), 8'((s | (m == 3'h1)) ? n_edges(es) : 0));
    chk(8'(n_tr - t0), 8'((m == 3'h2 || m == 3'h3) ? n_edges(ts) : 0));
    chk(8'(n_cap - c0),
        8'((m == 3'h5 || m == 3'h6) ? n_edges(cs[1:0]) + n_edges(cs[3:2]) : 0));
  endtask : t_edges

  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    results();
  end

  initial begin
    {sys_clk, nrst, evp, trp, cpp, eng} = '0;
    cyc(13);
    nrst = 1'b1;
    cyc(1);
    chk({tpin, cap, mode, lwr}, 8'h00);
    chk({4'h0, cfe, eve, tre, lwr}, 8'h00);
    t_pin();
    t_lock();
    for (int m = 0; m < 8; m++) begin
      t_edges(1'b0, 3'(m), tcwi_pkg::TCWI_EDGE_RISE, tcwi_pkg::TCWI_EDGE_RISE, 4'h5);
    end
    t_edges(1'b1, 3'h0, tcwi_pkg::TCWI_EDGE_RISE, tcwi_pkg::TCWI_EDGE_RISE, 4'h5);
    t_edges(1'b0, 3'h2, tcwi_pkg::TCWI_EDGE_FALL, tcwi_pkg::TCWI_EDGE_BOTH, 4'hE);
    t_edges(1'b1, 3'h6, tcwi_pkg::TCWI_EDGE_FALL, tcwi_pkg::TCWI_EDGE_NONE, 4'hE);
    t_edges(1'b0, 3'h1, tcwi_pkg::TCWI_EDGE_BOTH, tcwi_pkg::TCWI_EDGE_FALL, 4'h0);
    results();
  end
endmodule : tb
